/* hw/rgb_pkg.sv */
// constants, timing counts and carrier types of the rgbw light controller
// assumes a 20 MHz system clock; all config fields arrive already decoded
package rgb_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int BLINK_TICK_NS  = 16384000;
  localparam int BLINK_TICK_CYC = BLINK_TICK_NS / CLK_PERIOD_NS;
  localparam int PWM_STEP_NS    = 8000;
  localparam int PWM_STEP_CYC   = PWM_STEP_NS / CLK_PERIOD_NS;
  localparam int RAMP_UNIT_NS   = 64000;
  localparam int RAMP_UNIT_CYC  = RAMP_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // codes and fields
  // ----------------------------------------------------------------
  localparam int         NCH           = 4;
  localparam logic [10:0] DUTY_FULL    = 11'h400;
  localparam logic [1:0] VOUT_ADAPTIVE = 2'h0;
  localparam logic [1:0] PS_OFF        = 2'h0;
  localparam logic [1:0] PS_90         = 2'h1;
  localparam logic [1:0] PS_120        = 2'h2;
  localparam logic [9:0] SLOT_90       = 10'h100;
  localparam logic [9:0] SLOT_120      = 10'h155;
  localparam logic [9:0] SLOT_180      = 10'h200;
  localparam logic [2:0] ADDR_UPPER    = 3'h6;
  localparam logic [7:0] LEVEL_MAX     = 8'hff;

  typedef struct packed {
    logic                 global_enable;
    logic [3:0]           channel_enable_bit;
    logic [3:0]           direct_source_select;
    logic                 boost_enable;
    logic [1:0]           boost_output_mode;
    logic [3:0][7:0]      analog_current_code;
    logic [3:0][10:0]     dimming_duty_code;
    logic [7:0]           dimming_frequency_code;
    logic                 blink_mode_select;
    logic                 white_channel_blink_join;
    logic [7:0]           blink_period_code;
    logic [7:0]           blink_on_code;
    logic [7:0]           blink_repeat_count;
    logic                 post_blink_behavior;
    logic [1:0]           phase_shift_select;
    logic [3:0]           rise_step;
    logic [3:0]           fall_step;
  } rgb_cfg_t;

  typedef enum {ST_STANDBY, ST_RUN, ST_HOLD} rgb_state_t;
  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_SKIP} rgb_i2c_t;

endpackage

/* hw/rgb_dimming_blink_ctrl.sv */
// per-channel dimming, blinking, breathing and phase shift of a 4-ch led driver
// assumes cfg is driven by register logic on clk_sys; scl, sda, strap are pins
//
// Functional notes
// [R01] power-up in standby until enable set
// [R02] channel enable bit gates each channel
// [R03] direct-source channels leave boost feedback
// [R04] boost runs only with boost enable
// [R05] mode 00 regulates lowest active channel
// [R06] nonzero mode fixes output, ignores channels
// [R07] amplitude follows 8-bit analog code
// [R08] duty equals code over 1024, 400h full
// [R09] frequency code sets pwm period
// [R10] blink select; channel four needs join
// [R11] blink period is code times tick
// [R12] blink on-time is code times tick
// [R13] on-time beyond period means always on
// [R14] repeat count limits blinks, zero forever
// [R15] after blinks: dim on or standby
// [R16] breathing needs full blink and full duty
// [R17] unfinished rise falls from present level
// [R18] unfinished fall rises from present level
// [R19] turn-on order four, three, two, one
// [R20] shift field picks 0/90/120/180 spacing
// [R21] disabled channels keep others' slots
// [R22] address upper fixed, low four strapped
// [R23] enable write leaves cleared-enable standby
// [R24] standby darkens outputs, clears counters
`timescale 1ns/1ns
module rgb_dimming_blink_ctrl
  import rgb_pkg::*;
#(
  parameter int TICK_CYC = BLINK_TICK_CYC,
  parameter int STEP_CYC = PWM_STEP_CYC,
  parameter int RAMP_CYC = RAMP_UNIT_CYC
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            reset,
  // configuration
  input  wire rgb_cfg_t        cfg,
  // serial link pins
  input  wire logic            i2c_scl_i,
  input  wire logic            i2c_sda_i,
  output logic                 i2c_sda_o_q,
  output logic                 i2c_sda_oe_q,
  input  wire logic [3:0]      addr_strap,
  output logic                 addr_hit_q,
  output logic                 addr_read_q,
  // channel drive
  output logic [3:0]           led_on_q,
  output logic [3:0][7:0]      led_level_q,
  output logic [3:0]           direct_src_q,
  // boost control
  output logic                 boost_run_q,
  output logic [1:0]           boost_mode_q,
  output logic [3:0]           fb_mask_q,
  // status
  output logic                 standby_q,
  output logic                 blink_done_q
);

  localparam int TW = $clog2(TICK_CYC);
  localparam int RW = $clog2(RAMP_CYC);

  generate
    if (TICK_CYC < 2 || RAMP_CYC < 2 || STEP_CYC < 2 || STEP_CYC > 255) begin : g_chk
      $error("unsupported timing parameters");
    end
  endgenerate

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  rgb_state_t state_q, state_d;
  logic       run;
  logic       done_evt;

  assign run = (state_q == ST_RUN);

  // [R01] [R23] enable leaves standby
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STANDBY: if (cfg.global_enable) state_d = ST_RUN;
      ST_RUN: begin
        if (!cfg.global_enable) state_d = ST_STANDBY;
        // [R15] finite blink end, standby
        else if (done_evt && !cfg.post_blink_behavior) state_d = ST_HOLD;
      end
      ST_HOLD: if (!cfg.global_enable) state_d = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) state_q <= ST_STANDBY;
    else state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // pwm phase counter
  // ----------------------------------------------------------------
  logic [8:0] acc_q;
  logic [9:0] phase_q;
  logic [8:0] acc_sum;
  logic       pwm_step;
  logic [7:0] freq_eff;
  logic [9:0] slot;

  // [R09] frequency code scales step rate
  assign freq_eff = (cfg.dimming_frequency_code == 8'h00) ? 8'h01 : cfg.dimming_frequency_code;
  assign acc_sum  = acc_q + {1'b0, freq_eff};
  assign pwm_step = (acc_sum >= 9'(STEP_CYC));

  // [R20] spacing between turn-on edges
  assign slot = (cfg.phase_shift_select == PS_OFF) ? 10'h000 :
                (cfg.phase_shift_select == PS_90)  ? SLOT_90 :
                (cfg.phase_shift_select == PS_120) ? SLOT_120 : SLOT_180;

  // [R24] counters cleared in standby
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      acc_q   <= 9'h000;
      phase_q <= 10'h000;
    end else begin
      acc_q   <= pwm_step ? 9'(acc_sum - 9'(STEP_CYC)) : acc_sum;
      phase_q <= pwm_step ? 10'(phase_q + 10'h001) : phase_q;
    end
  end

  // ----------------------------------------------------------------
  // blink timing
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_q;
  logic [7:0]    pos_q;
  logic [7:0]    cycles_q;
  logic          tick;
  logic          cycle_end;
  logic          on_phase;
  logic          blink_act;

  assign tick      = (tick_cnt_q == TW'(TICK_CYC - 1));
  // [R11] period in ticks
  assign cycle_end = tick && (9'(pos_q) + 9'h001 >= {1'b0, cfg.blink_period_code});
  // [R12] [R13] on for code ticks, capped by period
  assign on_phase  = (cfg.blink_period_code == 8'h00) || (pos_q < cfg.blink_on_code);
  // [R14] zero repeats forever
  assign done_evt  = blink_act && cycle_end && (cfg.blink_repeat_count != 8'h00) &&
                     (8'(cycles_q + 8'h01) == cfg.blink_repeat_count);
  assign blink_act = cfg.blink_mode_select && !blink_done_q;

  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      tick_cnt_q   <= '0;
      pos_q        <= 8'h00;
      cycles_q     <= 8'h00;
      blink_done_q <= 1'b0;
    end else begin
      tick_cnt_q   <= tick ? '0 : TW'(tick_cnt_q + 1'b1);
      pos_q        <= cycle_end ? 8'h00 : (tick ? 8'(pos_q + 8'h01) : pos_q);
      cycles_q     <= (blink_act && cycle_end) ? 8'(cycles_q + 8'h01) : cycles_q;
      blink_done_q <= blink_done_q || done_evt;
    end
  end

  // ----------------------------------------------------------------
  // breathing ramp
  // ----------------------------------------------------------------
  logic [RW-1:0] unit_q;
  logic [3:0]    stepc_q;
  logic [7:0]    lvl_q;
  logic          breath;
  logic          unit_tick;
  logic          ramp_tick;
  logic [3:0]    step_sel;

  // [R16] all channels blink, all at full duty
  assign breath    = blink_act && cfg.white_channel_blink_join &&
                     (cfg.dimming_duty_code == {NCH{DUTY_FULL}});
  assign unit_tick = (unit_q == RW'(RAMP_CYC - 1));
  assign step_sel  = on_phase ? cfg.rise_step : cfg.fall_step;
  assign ramp_tick = unit_tick && (stepc_q >= step_sel);

  always_ff @(posedge clk_sys) begin
    if (reset || !run || !breath) begin
      unit_q  <= '0;
      stepc_q <= 4'h0;
      lvl_q   <= 8'h00;
    end else begin
      unit_q  <= unit_tick ? '0 : RW'(unit_q + 1'b1);
      stepc_q <= ramp_tick ? 4'h0 : (unit_tick ? 4'(stepc_q + 4'h1) : stepc_q);
      // [R17] [R18] ramp turns from present level
      if (ramp_tick && on_phase && lvl_q != LEVEL_MAX) lvl_q <= 8'(lvl_q + 8'h01);
      else if (ramp_tick && !on_phase && lvl_q != 8'h00) lvl_q <= 8'(lvl_q - 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // per-channel drive
  // ----------------------------------------------------------------
  logic [3:0]      on_d;
  logic [3:0][7:0] amp_d;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic [9:0] offs;
      logic [9:0] rel;
      logic       pwm_on;
      logic       blinks;
      logic       lit;
      logic [7:0] amp;
      // [R19] [R21] fixed slot per channel, four first
      assign offs   = 10'((NCH - 1 - gi) * slot);
      assign rel    = 10'(phase_q - offs);
      // [R08] duty compare, 400h always on
      assign pwm_on = ({1'b0, rel} < cfg.dimming_duty_code[gi]);
      // [R10] channel four blinks only when joined
      assign blinks = blink_act && ((gi < NCH - 1) || cfg.white_channel_blink_join);
      // [R07] amplitude from analog code
      assign amp    = (breath && lvl_q < cfg.analog_current_code[gi]) ?
                      lvl_q : cfg.analog_current_code[gi];
      assign lit    = breath ? (amp != 8'h00) : (!blinks || on_phase);
      // [R02] [R24] enable and run gate the channel
      assign on_d[gi]  = run && cfg.channel_enable_bit[gi] && pwm_on && lit;
      assign amp_d[gi] = (run && cfg.channel_enable_bit[gi]) ? amp : 8'h00;
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      led_on_q     <= 4'h0;
      led_level_q  <= '0;
      direct_src_q <= 4'h0;
      boost_run_q  <= 1'b0;
      boost_mode_q <= 2'h0;
      fb_mask_q    <= 4'h0;
      standby_q    <= 1'b1;
    end else begin
      led_on_q     <= on_d;
      led_level_q  <= amp_d;
      direct_src_q <= run ? (cfg.channel_enable_bit & cfg.direct_source_select) : 4'h0;
      // [R04] boost follows its enable
      boost_run_q  <= run && cfg.boost_enable;
      // [R05] [R06] adaptive vs fixed target
      boost_mode_q <= cfg.boost_output_mode;
      // [R03] [R05] feedback from active loop channels only
      fb_mask_q    <= (run && cfg.boost_enable && cfg.boost_output_mode == VOUT_ADAPTIVE) ?
                      (cfg.channel_enable_bit & ~cfg.direct_source_select) : 4'h0;
      standby_q    <= !run;
    end
  end

  // ----------------------------------------------------------------
  // serial address match
  // ----------------------------------------------------------------
  logic [2:0] scl_sy_q;
  logic [2:0] sda_sy_q;
  logic [3:0] strap1_q, strap2_q;
  logic [3:0] bits_q;
  logic [7:0] shift_q;
  rgb_i2c_t   i2c_q;
  logic       start_c, stop_c, scl_rise, scl_fall, addr_ok;

  assign start_c  = scl_sy_q[1] && scl_sy_q[2] && sda_sy_q[2] && !sda_sy_q[1];
  assign stop_c   = scl_sy_q[1] && scl_sy_q[2] && !sda_sy_q[2] && sda_sy_q[1];
  assign scl_rise = scl_sy_q[1] && !scl_sy_q[2];
  assign scl_fall = !scl_sy_q[1] && scl_sy_q[2];
  // [R22] fixed upper bits, strapped low nibble
  assign addr_ok  = (shift_q[7:1] == {ADDR_UPPER, strap2_q});

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      strap1_q <= 4'h0;
      strap2_q <= 4'h0;
    end else begin
      scl_sy_q <= {scl_sy_q[1:0], i2c_scl_i};
      sda_sy_q <= {sda_sy_q[1:0], i2c_sda_i};
      strap1_q <= addr_strap;
      strap2_q <= strap1_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      i2c_q        <= I2C_IDLE;
      bits_q       <= 4'h0;
      shift_q      <= 8'h00;
      i2c_sda_o_q  <= 1'b0;
      i2c_sda_oe_q <= 1'b0;
      addr_hit_q   <= 1'b0;
      addr_read_q  <= 1'b0;
    end else begin
      addr_hit_q <= 1'b0;
      if (start_c) begin
        i2c_q        <= I2C_ADDR;
        bits_q       <= 4'h0;
        i2c_sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        i2c_q        <= I2C_IDLE;
        i2c_sda_oe_q <= 1'b0;
      end else begin
        unique case (i2c_q)
          I2C_IDLE, I2C_SKIP: ;
          I2C_ADDR: begin
            if (scl_rise && bits_q != 4'h8) begin
              shift_q <= {shift_q[6:0], sda_sy_q[1]};
              bits_q  <= 4'(bits_q + 4'h1);
            end else if (scl_fall && bits_q == 4'h8) begin
              i2c_q        <= addr_ok ? I2C_ACK : I2C_SKIP;
              i2c_sda_oe_q <= addr_ok;
              addr_hit_q   <= addr_ok;
              addr_read_q  <= addr_ok ? shift_q[0] : addr_read_q;
            end
          end
          I2C_ACK: if (scl_fall) begin
            i2c_q        <= I2C_SKIP;
            i2c_sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_standby_dark: assert property (!run |=> (led_on_q == 4'h0) && standby_q) // [R24]
    else $error("channel lit in standby");
  a_enable_wakes: assert property ((state_q == ST_STANDBY && cfg.global_enable) |=> run) // [R01]
    else $error("enable did not start the device");
  a_chan_gate: assert property (!cfg.channel_enable_bit[0] |=> !led_on_q[0] && led_level_q[0] == 8'h00) // [R02]
    else $error("disabled channel driven");
  a_direct_out: assert property ((fb_mask_q & $past(cfg.direct_source_select)) == 4'h0) // [R03]
    else $error("direct channel in feedback");
  a_boost_on: assert property ((run && cfg.boost_enable) |=> boost_run_q ##1 (boost_run_q || !$past(cfg.boost_enable) || !$past(run))) // [R04]
    else $error("boost not following enable");
  a_fixed_mode: assert property ((cfg.boost_output_mode != VOUT_ADAPTIVE) |=> fb_mask_q == 4'h0) // [R06]
    else $error("feedback used in fixed mode");
  a_full_duty: assert property ((run && cfg.channel_enable_bit[1] && !cfg.blink_mode_select && cfg.dimming_duty_code[1] == DUTY_FULL) |=> led_on_q[1]) // [R08]
    else $error("full duty channel dark");
  a_zero_duty: assert property ((cfg.dimming_duty_code[2] == 11'h000) |=> !led_on_q[2]) // [R08]
    else $error("zero duty channel lit");
  a_blink_hold: assert property ((run && cfg.global_enable && done_evt && !cfg.post_blink_behavior) |=> state_q == ST_HOLD ##1 !run) // [R15]
    else $error("no standby after blinks");
  a_repeat_count: assert property ($rose(blink_done_q) |-> $past(cycles_q) + 8'h01 == $past(cfg.blink_repeat_count)) // [R14]
    else $error("blink count mismatch");
  a_ack_only_hit: assert property ($rose(i2c_sda_oe_q) |-> addr_hit_q && $past(addr_ok)) // [R22]
    else $error("ack without address match");

  c_running:    cover property (run ##1 led_on_q != 4'h0);
  c_blink_done: cover property ($rose(blink_done_q));
  c_breathing:  cover property (breath && lvl_q != 8'h00);
  c_addr_hit:   cover property (addr_hit_q);

endmodule // rgb_dimming_blink_ctrl

/* verif/rgb_i2c_host.sv */
// i2c host model: start, address byte, ack slot and stop
// assumes the bench resolves sda with a pull-up; scl idles high between frames
`timescale 1ns/1ns
module rgb_i2c_host (
  // clock
  input  wire logic clk_sys,
  // pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ------------------------------
  // bus cycles, 200 ns half period
  // ------------------------------
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  // data moves one cycle after scl falls, so it never mimics a start
  task automatic put(input logic b);
    @(negedge clk_sys);
    sda_low_o = ~b;
    repeat (3) @(negedge clk_sys);
    scl_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask
  task automatic send_addr(input logic [6:0] a, input logic rw, output logic ack);
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b0;
    for (int i = 6; i >= 0; i--) put(a[i]);
    put(rw);
    @(negedge clk_sys);
    sda_low_o = 1'b0;
    repeat (3) @(negedge clk_sys);
    scl_o = 1'b1;
    half();
    ack = ~sda_i;
    scl_o = 1'b0;
    @(negedge clk_sys);
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
  endtask
endmodule // rgb_i2c_host

/* verif/test_rgb_dimming_blink_ctrl.sv */
// self-checking bench of the rgbw dimming, blink, breathing and phase shift block
// assumes rgb_pkg and rgb_i2c_host are compiled first
`timescale 1ns/1ns
`define CHK(g, e, m) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("mismatch at %0t: %s", $time, m); \
  end \
end
module test_rgb_dimming_blink_ctrl;
  import rgb_pkg::*;
  localparam int TICK = 20;
  localparam int STEP = 16;
  logic            clk_sys;
  logic            reset;
  rgb_cfg_t        cfg;
  logic [3:0]      addr_strap;
  logic            scl;
  logic            host_low;
  logic            sda_o;
  logic            sda_oe;
  wire logic       sda;
  logic            hit;
  logic            rd;
  logic [3:0]      on;
  logic [3:0][7:0] lvl;
  logic [3:0]      dsrc;
  logic            brun;
  logic [1:0]      bmode;
  logic [3:0]      fbm;
  logic            stby;
  logic            done;
  logic [6:0]      a;
  logic            rw;
  logic            ack;
  int              error_cnt;
  int              checks_done;
  int              hits;
  int              h0;
  int              n;
  int              rp;
  int              maxl;
  int              lbad;
  int              cnt[4];
  int              first[4];
  int              fc[3] = '{4, 8, 16};

  // ------------------------------
  // design, host and open-drain wire
  // ------------------------------
  assign sda = (host_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
  rgb_dimming_blink_ctrl #(.TICK_CYC(TICK), .STEP_CYC(STEP), .RAMP_CYC(4)) uut (
    .clk_sys(clk_sys), .reset(reset), .cfg(cfg), .i2c_scl_i(scl), .i2c_sda_i(sda),
    .i2c_sda_o_q(sda_o), .i2c_sda_oe_q(sda_oe), .addr_strap(addr_strap),
    .addr_hit_q(hit), .addr_read_q(rd), .led_on_q(on), .led_level_q(lvl),
    .direct_src_q(dsrc), .boost_run_q(brun), .boost_mode_q(bmode), .fb_mask_q(fbm),
    .standby_q(stby), .blink_done_q(done));
  rgb_i2c_host host (.clk_sys(clk_sys), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (hit === 1'b1) hits++;
  initial begin
    #4000000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic results();
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic restart();
    cfg.global_enable = 1'b0;
    tick(3);
    cfg.global_enable = 1'b1;
    tick(4);
  endtask
  task automatic measure(input int len);
    cnt = '{default: 0};
    first = '{default: -1};
    maxl = 0;
    lbad = 0;
    for (int k = 0; k < len; k++) begin
      tick(1);
      if (int'(lvl[0]) > maxl) maxl = int'(lvl[0]);
      for (int i = 0; i < 4; i++) if (on[i] === 1'b1) begin
        cnt[i]++;
        if (first[i] < 0) first[i] = k;
        if (lvl[i] !== cfg.analog_current_code[i]) lbad++;
      end
    end
  endtask
  function automatic int exp_pwm(input logic [10:0] d, input int code);
    return ((d > DUTY_FULL) ? 1024 : int'(d)) * STEP / code;
  endfunction
  function automatic int slot(input logic [1:0] ps);
    return (ps == PS_OFF) ? 0 : (ps == PS_90) ? int'(SLOT_90) :
           (ps == PS_120) ? int'(SLOT_120) : int'(SLOT_180);
  endfunction

  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    error_cnt = 0;
    checks_done = 0;
    hits = 0;
    reset = 1'b1;
    cfg = '0;
    cfg.boost_enable = 1'b1;
    cfg.dimming_frequency_code = 8'h10;
    addr_strap = 4'h5;
    void'($urandom(15));
    tick(12);
    reset = 1'b0;
    tick(6);
    `CHK(stby, 1'b1, "not in standby")
    `CHK({on, brun}, 5'h00, "active in standby")
    for (int m = 0; m < 8; m++) begin
      cfg.boost_output_mode = m[1:0];
      cfg.boost_enable = m[2];
      cfg.channel_enable_bit = 4'($urandom);
      cfg.direct_source_select = 4'($urandom);
      restart();
      `CHK(stby, 1'b0, "no run after enable")
      `CHK(brun, m[2], "boost run")
      `CHK(bmode, m[1:0], "boost mode")
      `CHK(dsrc, cfg.channel_enable_bit & cfg.direct_source_select, "direct source")
      `CHK(fbm, (m[1:0] == 0 && m[2]) ? cfg.channel_enable_bit & ~cfg.direct_source_select
                : 4'h0, "feedback mask")
    end
    foreach (fc[j]) for (int r = 0; r < 2; r++) begin
      cfg.dimming_frequency_code = 8'(fc[j]);
      cfg.phase_shift_select = 2'($urandom);
      cfg.channel_enable_bit = (r == 0) ? 4'hf : 4'($urandom);
      for (int i = 0; i < 4; i++) begin
        cfg.dimming_duty_code[i] = 11'($urandom_range(1100));
        cfg.analog_current_code[i] = 8'($urandom_range(255, 1));
      end
      if (r == 0) cfg.dimming_duty_code = {11'h3ff, 11'h401, 11'h000, 11'h400};
      tick(4);
      measure(1024 * STEP / fc[j]);
      for (int i = 0; i < 4; i++)
        `CHK(cnt[i], cfg.channel_enable_bit[i] ? exp_pwm(cfg.dimming_duty_code[i], fc[j])
             : 0, "pwm on time")
      `CHK(lbad, 0, "amplitude code")
    end
    cfg.dimming_frequency_code = 8'h10;
    cfg.dimming_duty_code = {4{11'h001}};
    for (int p = 0; p < 4; p++) begin
      cfg.phase_shift_select = p[1:0];
      cfg.channel_enable_bit = (p == 1) ? 4'hd : 4'hf;
      tick(4);
      measure(1024);
      for (int i = 0; i < 3; i++) if (cfg.channel_enable_bit[i])
        `CHK((first[i] - first[3] + 2048) % 1024, ((3 - i) * slot(p[1:0])) % 1024,
             "turn-on slot")
    end
    cfg.phase_shift_select = 2'h0;
    cfg.dimming_duty_code = {{3{11'h400}}, 11'h3ff};
    cfg.channel_enable_bit = 4'hf;
    cfg.blink_period_code = 8'h04;
    for (int b = 0; b < 4; b++) begin
      cfg.blink_mode_select = (b != 0);
      cfg.white_channel_blink_join = (b == 0 || b == 2);
      cfg.blink_on_code = (b == 3) ? 8'h06 : 8'h01;
      restart();
      measure(800);
      for (int i = 1; i < 4; i++)
        `CHK(cnt[i], ((b == 1 || b == 2) && (i < 3 || b == 2)) ? 10 * TICK : 800,
             "blink on time")
      `CHK(done, 1'b0, "endless blink ended")
    end
    cfg.blink_on_code = 8'h01;
    for (int r = 0; r < 2; r++) begin
      rp = r ? 255 : 1;
      cfg.blink_repeat_count = 8'(rp);
      cfg.post_blink_behavior = r[0];
      restart();
      n = 0;
      while (done !== 1'b1 && n < 30000) begin
        tick(1);
        n++;
      end
      `CHK(n > rp * 80 - 16 && n < rp * 80 + 8, 1'b1, "blink count")
      tick(4);
      `CHK(stby, ~r[0], "after blinking")
      `CHK(on[3:1], r ? 3'h7 : 3'h0, "drive after blinking")
    end
    cfg.blink_repeat_count = 8'h00;
    cfg.white_channel_blink_join = 1'b1;
    cfg.analog_current_code = {4{8'hff}};
    for (int s = 0; s < 3; s++) begin
      cfg.dimming_duty_code = {{3{11'h400}}, (s == 2) ? 11'h3ff : 11'h400};
      cfg.fall_step = (s == 1) ? 4'hf : 4'h0;
      cfg.rise_step = (s == 0) ? 4'h1 : 4'h0;
      restart();
      measure(800);
      `CHK(maxl > 0 && maxl < 4, s == 0, "rise cut short")
      `CHK(maxl > 8 && maxl < 255, s == 1, "fall resumed")
      `CHK(maxl == 255, s == 2, "breathing gate")
    end
    cfg.blink_mode_select = 1'b0;
    for (int t = 0; t < 6; t++) begin
      addr_strap = 4'($urandom);
      rw = 1'($urandom);
      tick(4);
      a = {ADDR_UPPER, addr_strap} ^ (t[0] ? 7'(1 << $urandom_range(6)) : 7'h00);
      h0 = hits;
      host.send_addr(a, rw, ack);
      `CHK(ack, ~t[0], "address ack")
      `CHK(hits - h0, t[0] ? 0 : 1, "address hit")
      if (!t[0]) `CHK(rd, rw, "direction bit")
    end
    cfg.global_enable = 1'b0;
    tick(4);
    `CHK(stby, 1'b1, "standby")
    `CHK({on, lvl}, 36'h0, "dark in standby")
    results();
  end
endmodule // test_rgb_dimming_blink_ctrl
